// *** inc/bgdc_pkg.sv ***
// Purpose: types of the gate drive control block
// Assumes: nothing beyond the constants header
// Notes:   state record is registered as one word
package bgdc_pkg;

   typedef logic [11:0] bgdc_cnt_t;
   typedef logic [19:0] bgdc_pu_t;

   typedef enum logic [3:0] {
      BGDC_OFF   = 4'h1,
      BGDC_PWRUP = 4'h2,
      BGDC_RUN   = 4'h4,
      BGDC_FAULT = 4'h8
   } bgdc_state_t;

   typedef struct packed {
      logic [2:0]            s1_en;
      logic [2:0]            s2_en;
      logic [2:0]            en_d;
      logic [2:0]            s1_pwm;
      logic [2:0]            s2_pwm;
      logic                  s1_sleep;
      logic                  s2_sleep;
      logic                  s1_uv;
      logic                  s2_uv;
      logic                  s1_gd;
      logic                  s2_gd;
      logic [5:0]            s1_vds;
      logic [5:0]            s2_vds;
      logic                  s1_shunt;
      logic                  s2_shunt;
      logic                  s1_ot;
      logic                  s2_ot;
      bgdc_state_t           state;
      bgdc_pu_t              pu_cnt;
      logic [2:0]            gate_hi;
      logic [2:0]            gate_lo;
      logic [2:0]            hiz;
      logic [2:0][11:0]      dead_cnt;
      logic [2:0][11:0]      lsp_cnt;
      bgdc_cnt_t             blank;
      bgdc_cnt_t             dead_set;
      bgdc_cnt_t             dead_cyc;
      bgdc_cnt_t             lsp_cyc;
      logic [3:0]            flt;
      logic                  fault_oe;
      logic                  fault_lvl;
      logic                  waitreq;
      logic [31:0]           rdata;
   } bgdc_st_t;

endpackage

// *** inc/bgdc_regs.svh ***
// Purpose: constants of the gate drive control block
// Assumes: 200 MHz core clock, byte addressed register words
// Notes:   times kept in printed units, cycle counts derived
//
// What this block does
// - power-up starts only above input undervoltage level
// - stay non-functional until gate supply is good
// - power-up takes 1 to 2 ms
// - sleep low disables everything, inputs ignored
// - leaving sleep reruns full power-up
// - enable low: both gates off, pwm ignored
// - enable high: pwm selects high or low side
// - enable rising edge fires low-side pulse
// - low-side pulse lasts typically 1.8 us
// - fault line pulled low while fault present
// - drain-source over reference: short circuit fault
// - shunt over threshold: overcurrent latched fault
// - faults latch until sleep or undervoltage reset
// - blank drain-source monitor after gate switching
// - dead time before complementary turn-on, shared
// - dead time 3.7 ns per kohm, 30ns min
// - input undervoltage resets logic, then power-up
// - gate supply loss after power-up latches fault
// - overtemperature latches fault, disables all
`ifndef BGDC_REGS_SVH
`define BGDC_REGS_SVH

`define BGDC_CLK_NS          5
`define BGDC_PWRUP_MIN_MS    1
`define BGDC_PWRUP_MAX_MS    2
`define BGDC_PWRUP_CYC       (`BGDC_PWRUP_MIN_MS * 1000000 / `BGDC_CLK_NS)
`define BGDC_LSP_NS          1800
`define BGDC_LSP_CYC         (`BGDC_LSP_NS / `BGDC_CLK_NS)
`define BGDC_DEAD_MIN_NS     30
`define BGDC_DEAD_MIN_CYC    ((`BGDC_DEAD_MIN_NS + `BGDC_CLK_NS - 1) / `BGDC_CLK_NS)
`define BGDC_DEAD_OPEN_US    6
`define BGDC_DEAD_OPEN_CYC   (`BGDC_DEAD_OPEN_US * 1000 / `BGDC_CLK_NS)
`define BGDC_DEAD_KOHM_X10   37
`define BGDC_DEAD_DIV        (10 * `BGDC_CLK_NS)
`define BGDC_DEAD_OPEN_CODE  12'hFFF
`define BGDC_BLANK_CYC       100

`define BGDC_OFS_DEAD        4'h0
`define BGDC_OFS_LSP         4'h4
`define BGDC_OFS_STATUS      4'h8
`define BGDC_RST_DEAD        12'h000

`define BGDC_FLT_SC          0
`define BGDC_FLT_OC          1
`define BGDC_FLT_GD          2
`define BGDC_FLT_OT          3

`endif

// *** rtl/bgdc_core.sv ***
// Purpose: sequencing, gate decode, dead time and fault latch
// Assumes: comparator and pin inputs asynchronous, two-stage synchronised to i_clk
// Notes:   registers reached over Avalon-MM with waitrequest
//
// Design decisions made here: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "bgdc_regs.svh"

module bgdc_core #(
   parameter int PWRUP_CYCLES = `BGDC_PWRUP_CYC,
   parameter int BLANK_CYCLES = `BGDC_BLANK_CYC
) (
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_reset_n,
   input  wire logic        i_ce,
   // supply monitors
   input  wire logic        i_vin_above_uvlo,
   input  wire logic        i_gate_drive_supply_ok,
   // controller pins
   input  wire logic        i_sleep_n_input,
   input  wire logic [2:0]  i_phase_enable_input,
   input  wire logic [2:0]  i_phase_pwm_input,
   // comparators
   input  wire logic [5:0]  i_vds_over_reference,
   input  wire logic        i_shunt_over_level,
   input  wire logic        i_overtemp,
   // gate commands
   output logic      [2:0]  o_gate_hi,
   output logic      [2:0]  o_gate_lo,
   output logic      [2:0]  o_phase_node_hiz,
   // open-drain fault line
   input  wire logic        i_fault_n_output_in,
   output logic             o_fault_n_output_out,
   output logic             o_fault_n_output_oe,
   // avalon slave
   input  wire logic [3:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   input  wire logic [3:0]  i_avs_byteenable,
   output logic      [31:0] o_avs_readdata,
   output logic             o_avs_waitrequest
);

   localparam bgdc_pkg::bgdc_pu_t  PU_LAST = bgdc_pkg::bgdc_pu_t'(PWRUP_CYCLES - 1);
   localparam bgdc_pkg::bgdc_cnt_t BLANK   = bgdc_pkg::bgdc_cnt_t'(BLANK_CYCLES);
   localparam bgdc_pkg::bgdc_cnt_t D_MIN   = bgdc_pkg::bgdc_cnt_t'(`BGDC_DEAD_MIN_CYC);
   localparam bgdc_pkg::bgdc_cnt_t D_OPEN  = bgdc_pkg::bgdc_cnt_t'(`BGDC_DEAD_OPEN_CYC);
   localparam bgdc_pkg::bgdc_cnt_t LSP_RST = bgdc_pkg::bgdc_cnt_t'(`BGDC_LSP_CYC);

   if (PWRUP_CYCLES < 2 || PWRUP_CYCLES > 20'hFFFFF) begin : g_bad_pu
      $error("power-up count out of range");
   end
   if (BLANK_CYCLES < 1 || BLANK_CYCLES > 12'hFFF) begin : g_bad_blank
      $error("blanking count out of range");
   end

   // byte lane merge into a 12-bit field
   function automatic bgdc_pkg::bgdc_cnt_t lane_merge(
      input bgdc_pkg::bgdc_cnt_t old,
      input logic [31:0]         wd,
      input logic [3:0]          be
   );
      lane_merge = {be[1] ? wd[11:8] : old[11:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction

   // resistance in kohm to dead time cycles
   function automatic bgdc_pkg::bgdc_cnt_t dead_calc(input bgdc_pkg::bgdc_cnt_t r);
      logic [17:0] p;
      p = 18'(r) * 18'(`BGDC_DEAD_KOHM_X10) + 18'(`BGDC_DEAD_DIV - 1);
      p = p / 18'(`BGDC_DEAD_DIV);
      if (r == `BGDC_DEAD_OPEN_CODE) begin
         dead_calc = D_OPEN;
      end else if (p[11:0] < D_MIN) begin
         dead_calc = D_MIN;
      end else begin
         dead_calc = p[11:0];
      end
   endfunction

   bgdc_pkg::bgdc_st_t st;
   bgdc_pkg::bgdc_st_t next_st;

   logic [3:0] new_flt;
   logic       run_now;
   logic [2:0] rise;
   logic [2:0] pulse;
   logic [2:0] want_hi;
   logic [2:0] want_lo;
   logic       wr_take;

   always_comb begin
      next_st = st;
      new_flt = 4'h0;
      rise    = 3'h0;
      pulse   = 3'h0;
      want_hi = 3'h0;
      want_lo = 3'h0;
      wr_take = i_avs_write && !st.waitreq;

      // two-stage synchronisers
      next_st.s1_en    = i_phase_enable_input;
      next_st.s2_en    = st.s1_en;
      next_st.en_d     = st.s2_en;
      next_st.s1_pwm   = i_phase_pwm_input;
      next_st.s2_pwm   = st.s1_pwm;
      next_st.s1_sleep = i_sleep_n_input;
      next_st.s2_sleep = st.s1_sleep;
      next_st.s1_uv    = i_vin_above_uvlo;
      next_st.s2_uv    = st.s1_uv;
      next_st.s1_gd    = i_gate_drive_supply_ok;
      next_st.s2_gd    = st.s1_gd;
      next_st.s1_vds   = i_vds_over_reference;
      next_st.s2_vds   = st.s1_vds;
      next_st.s1_shunt = i_shunt_over_level;
      next_st.s2_shunt = st.s1_shunt;
      next_st.s1_ot    = i_overtemp;
      next_st.s2_ot    = st.s1_ot;

      // bus slave: waitrequest drops one cycle after request
      next_st.waitreq = 1'b1;
      if (st.waitreq && (i_avs_read || i_avs_write)) begin
         next_st.waitreq = 1'b0;
         next_st.rdata   = 32'h0;
         if (i_avs_read) begin
            case (i_avs_address)
               `BGDC_OFS_DEAD: begin
                  next_st.rdata = {20'h0, st.dead_set};
               end
               `BGDC_OFS_LSP: begin
                  next_st.rdata = {20'h0, st.lsp_cyc};
               end
               `BGDC_OFS_STATUS: begin
                  next_st.rdata = {5'h0, st.dead_cyc, i_fault_n_output_in,
                                   st.gate_lo, st.gate_hi, st.state, st.flt};
               end
               default: begin
                  next_st.rdata = 32'h0;
               end
            endcase
         end
      end
      if (wr_take) begin
         case (i_avs_address)
            `BGDC_OFS_DEAD: begin
               next_st.dead_set = lane_merge(st.dead_set, i_avs_writedata,
                                             i_avs_byteenable);
               next_st.dead_cyc = dead_calc(next_st.dead_set);
            end
            `BGDC_OFS_LSP: begin
               next_st.lsp_cyc = lane_merge(st.lsp_cyc, i_avs_writedata,
                                            i_avs_byteenable);
               if (next_st.lsp_cyc == 12'h000) begin
                  next_st.lsp_cyc = 12'h001;
               end
            end
            default: begin
               next_st.rdata = st.rdata;
            end
         endcase
      end

      // fault sources, only while running
      if (st.state == bgdc_pkg::BGDC_RUN) begin
         new_flt[`BGDC_FLT_SC] = (|st.s2_vds) && (st.blank == 12'h000);
         new_flt[`BGDC_FLT_OC] = st.s2_shunt;
         new_flt[`BGDC_FLT_GD] = !st.s2_gd;
         new_flt[`BGDC_FLT_OT] = st.s2_ot;
      end
      next_st.flt = st.flt | new_flt;

      case (st.state)
         bgdc_pkg::BGDC_OFF: begin
            next_st.pu_cnt = '0;
            if (st.s2_uv && st.s2_sleep) begin
               next_st.state = bgdc_pkg::BGDC_PWRUP;
            end
         end
         bgdc_pkg::BGDC_PWRUP: begin
            if (st.pu_cnt != PU_LAST) begin
               next_st.pu_cnt = st.pu_cnt + 20'h00001;
            end else if (st.s2_gd) begin
               next_st.state = bgdc_pkg::BGDC_RUN;
            end
         end
         bgdc_pkg::BGDC_RUN: begin
            if (|new_flt) begin
               next_st.state = bgdc_pkg::BGDC_FAULT;
            end
         end
         bgdc_pkg::BGDC_FAULT: begin
            next_st.state = bgdc_pkg::BGDC_FAULT;
         end
         default: begin
            next_st.state = bgdc_pkg::BGDC_OFF;
         end
      endcase

      // sleep or undervoltage resets sequence and faults
      if (!st.s2_uv || !st.s2_sleep) begin
         next_st.state = bgdc_pkg::BGDC_OFF;
         next_st.flt   = 4'h0;
      end
      run_now = (next_st.state == bgdc_pkg::BGDC_RUN);

      // per phase decode, auto pulse and dead time
      for (int i = 0; i < 3; i++) begin
         rise[i]  = st.s2_en[i] && !st.en_d[i];
         pulse[i] = rise[i] || (st.lsp_cnt[i] != 12'h000);
         if (!run_now || !st.s2_en[i]) begin
            next_st.lsp_cnt[i] = 12'h000;
         end else if (rise[i]) begin
            next_st.lsp_cnt[i] = st.lsp_cyc - 12'h001;
         end else if (st.lsp_cnt[i] != 12'h000) begin
            next_st.lsp_cnt[i] = st.lsp_cnt[i] - 12'h001;
         end
         want_hi[i] = run_now && st.s2_en[i] && st.s2_pwm[i] && !pulse[i];
         want_lo[i] = run_now && st.s2_en[i] && (!st.s2_pwm[i] || pulse[i]);

         next_st.gate_hi[i] = 1'b0;
         next_st.gate_lo[i] = 1'b0;
         if (st.dead_cnt[i] != 12'h000) begin
            next_st.dead_cnt[i] = st.dead_cnt[i] - 12'h001;
         end
         if (want_hi[i] && st.gate_hi[i]) begin
            next_st.gate_hi[i] = 1'b1;
         end else if (want_lo[i] && st.gate_lo[i]) begin
            next_st.gate_lo[i] = 1'b1;
         end else if (st.gate_hi[i] || st.gate_lo[i]) begin
            next_st.dead_cnt[i] = st.dead_cyc - 12'h001;
         end else if (st.dead_cnt[i] == 12'h000) begin
            next_st.gate_hi[i] = want_hi[i];
            next_st.gate_lo[i] = want_lo[i];
         end
         next_st.hiz[i] = !next_st.gate_hi[i] && !next_st.gate_lo[i];
      end

      // restart blanking on any gate change
      if ({next_st.gate_hi, next_st.gate_lo} != {st.gate_hi, st.gate_lo}) begin
         next_st.blank = BLANK;
      end else if (st.blank != 12'h000) begin
         next_st.blank = st.blank - 12'h001;
      end

      next_st.fault_oe  = (next_st.state == bgdc_pkg::BGDC_FAULT);
      next_st.fault_lvl = 1'b0;
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st          <= '0;
         st.state    <= bgdc_pkg::BGDC_OFF;
         st.hiz      <= 3'h7;
         st.dead_set <= `BGDC_RST_DEAD;
         st.dead_cyc <= D_MIN;
         st.lsp_cyc  <= LSP_RST;
         st.waitreq  <= 1'b1;
      end else if (i_ce) begin
         st <= next_st;
      end
   end

   assign o_gate_hi            = st.gate_hi;
   assign o_gate_lo            = st.gate_lo;
   assign o_phase_node_hiz     = st.hiz;
   assign o_fault_n_output_out = st.fault_lvl;
   assign o_fault_n_output_oe  = st.fault_oe;
   assign o_avs_readdata       = st.rdata;
   assign o_avs_waitrequest    = st.waitreq;

   default clocking cb @(posedge i_clk iff i_ce);
   endclocking
   default disable iff (!i_reset_n);

   a_no_overlap: assert property ((o_gate_hi & o_gate_lo) == 3'h0)
      else $error("high and low gate on together");

   a_dead_gap: assert property ($fell(o_gate_lo[0]) |-> (!o_gate_hi[0]) [*6])
      else $error("dead time shorter than minimum");

   a_idle_gates_off: assert property (st.state != bgdc_pkg::BGDC_RUN |->
      o_gate_hi == 3'h0 && o_gate_lo == 3'h0)
      else $error("gates driven outside run");

   a_sleep_resets: assert property (!st.s2_sleep |=>
      st.state == bgdc_pkg::BGDC_OFF && st.flt == 4'h0)
      else $error("sleep did not reset");

   a_uv_resets: assert property (!st.s2_uv |=> st.state == bgdc_pkg::BGDC_OFF)
      else $error("undervoltage did not reset");

   a_fault_holds: assert property (st.state == bgdc_pkg::BGDC_FAULT && st.s2_uv
      && st.s2_sleep |=> st.state == bgdc_pkg::BGDC_FAULT)
      else $error("fault released without reset");

   a_fault_line: assert property (st.state == bgdc_pkg::BGDC_FAULT |->
      o_fault_n_output_oe && !o_fault_n_output_out)
      else $error("fault line not pulled low");

   a_shunt_trip: assert property (st.state == bgdc_pkg::BGDC_RUN && st.s2_shunt
      && st.s2_uv && st.s2_sleep |=> st.state == bgdc_pkg::BGDC_FAULT)
      else $error("overcurrent not latched");

   a_sc_trip: assert property (st.state == bgdc_pkg::BGDC_RUN && (|st.s2_vds)
      && st.blank == 12'h000 && st.s2_uv && st.s2_sleep
      |=> st.state == bgdc_pkg::BGDC_FAULT && st.flt[`BGDC_FLT_SC])
      else $error("short circuit not latched");

   a_gd_trip: assert property (st.state == bgdc_pkg::BGDC_RUN && !st.s2_gd
      && st.s2_uv && st.s2_sleep |=> st.state == bgdc_pkg::BGDC_FAULT)
      else $error("gate supply loss not latched");

   a_ot_trip: assert property (st.state == bgdc_pkg::BGDC_RUN && st.s2_ot
      && st.s2_uv && st.s2_sleep |=> st.state == bgdc_pkg::BGDC_FAULT)
      else $error("overtemperature not latched");

   a_pwrup_gd_wait: assert property (st.state == bgdc_pkg::BGDC_PWRUP && !st.s2_gd
      |=> st.state != bgdc_pkg::BGDC_RUN)
      else $error("run entered without gate supply");

   a_blank_masks: assert property (st.state == bgdc_pkg::BGDC_RUN
      && st.blank != 12'h000 && !st.s2_shunt && st.s2_gd && !st.s2_ot
      && st.s2_uv && st.s2_sleep |=> st.state == bgdc_pkg::BGDC_RUN)
      else $error("monitor not blanked");

   a_pwrup_time: assert property (st.state == bgdc_pkg::BGDC_RUN
      && $past(st.state) == bgdc_pkg::BGDC_PWRUP |-> $past(st.pu_cnt) == PU_LAST)
      else $error("power-up too short");

   a_auto_pulse: assert property (st.state == bgdc_pkg::BGDC_RUN
      && rise[0] && run_now |=> ##1 o_gate_hi[0] == 1'b0)
      else $error("high side on during auto pulse");

   a_disabled_off: assert property (run_now && !st.s2_en[1] |=>
      !o_gate_hi[1] && !o_gate_lo[1] && o_phase_node_hiz[1])
      else $error("disabled phase driven");

   a_hiz_match: assert property (o_phase_node_hiz == ~(o_gate_hi | o_gate_lo))
      else $error("phase node state wrong");

   a_bus_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
      |=> !o_avs_waitrequest)
      else $error("bus request not answered");

   a_sync_pwm: assert property ($rose(st.s2_pwm[2]) |-> $past(i_phase_pwm_input[2], 2))
      else $error("pwm not through synchroniser");

   c_reach_run: cover property (st.state == bgdc_pkg::BGDC_RUN);
   c_reach_fault: cover property (st.state == bgdc_pkg::BGDC_FAULT);
   c_auto_pulse: cover property (rise[0] && run_now ##1 o_gate_lo[0]);
   c_high_drive: cover property (o_gate_hi[2] ##1 !o_gate_hi[2]);

endmodule // bgdc_core

// *** verif/bgdc_ctrl_model.sv ***
// Purpose: controller model driving sleep, enable and pwm pins
// Assumes: pins change only just after a rising clock edge
// Notes:   sleep starts low, as the internal pulldown holds it
`timescale 1ns/1ps

module bgdc_ctrl_model (
   // clock
   input  wire logic       i_clk,
   // pins toward the driver
   output logic            o_sleep_n,
   output logic      [2:0] o_enable,
   output logic      [2:0] o_pwm
);
   initial begin
      o_sleep_n = 1'b0;
      o_enable  = 3'h0;
      o_pwm     = 3'h0;
   end

   // sleep actively driven high whenever operation is wanted
   task automatic drive(input logic sl, input logic [2:0] en, input logic [2:0] pw);
      @(posedge i_clk);
      o_sleep_n <= sl;
      o_enable  <= en;
      o_pwm     <= pw;
   endtask
endmodule // bgdc_ctrl_model

// *** verif/tb_top.sv ***
// Purpose: self-checking bench of the gate drive control block
// Assumes: controller model drives sleep, enable and pwm pins
// Notes:   power-up and blanking counts shortened for run time
`timescale 1ns/1ps
`include "bgdc_regs.svh"

module tb_top;
   localparam int PU    = 20;
   localparam int BL    = 5;
   localparam int LIMIT = 30000;

   logic        clk;
   logic        rst_n;
   logic        uv_ok;
   logic        gd_ok;
   logic [5:0]  vds;
   logic        shunt;
   logic        ot;
   logic [3:0]  addr;
   logic        rd;
   logic        wr;
   logic [31:0] wdata;
   logic        sleep_n;
   logic [2:0]  en;
   logic [2:0]  pwm;
   logic [2:0]  g_hi;
   logic [2:0]  g_lo;
   logic [2:0]  hiz;
   logic        f_out;
   logic        f_oe;
   logic [31:0] rdata;
   logic        wreq;
   wire         f_wire;
   int          n_mismatch = 0;
   int          check_count = 0;
   int          cyc = 0;

   // external pull-up on the fault wire
   assign f_wire = f_oe ? 1'b0 : 1'b1;

   bgdc_ctrl_model ctrl_u (.i_clk(clk), .o_sleep_n(sleep_n), .o_enable(en), .o_pwm(pwm));

   bgdc_core #(.PWRUP_CYCLES(PU), .BLANK_CYCLES(BL)) dut_u (
      .i_clk(clk), .i_reset_n(rst_n), .i_ce(1'b1),
      .i_vin_above_uvlo(uv_ok), .i_gate_drive_supply_ok(gd_ok),
      .i_sleep_n_input(sleep_n), .i_phase_enable_input(en), .i_phase_pwm_input(pwm),
      .i_vds_over_reference(vds), .i_shunt_over_level(shunt), .i_overtemp(ot),
      .o_gate_hi(g_hi), .o_gate_lo(g_lo), .o_phase_node_hiz(hiz),
      .i_fault_n_output_in(f_wire), .o_fault_n_output_out(f_out),
      .o_fault_n_output_oe(f_oe), .i_avs_address(addr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF),
      .o_avs_readdata(rdata), .o_avs_waitrequest(wreq));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         n_mismatch++;
         end_sim();
      end
   end

   task automatic end_sim;
      if (n_mismatch == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic is_wr, input logic [3:0] a, input logic [31:0] wd,
                      output logic [31:0] d);
      @(posedge clk);
      rd    <= ~is_wr;
      wr    <= is_wr;
      addr  <= a;
      wdata <= wd;
      do begin
         @(posedge clk);
      end while (wreq !== 1'b0);
      d = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task automatic wait_st(input logic [3:0] exp);
      logic [31:0] s;
      do bus(1'b0, `BGDC_OFS_STATUS, 32'h0, s);
      while (s[7:4] !== exp);
   endtask

   task automatic pwr_up(output int n);
      int t0;
      uv_ok <= 1'b1;
      gd_ok <= 1'b1;
      vds   <= 6'h00;
      shunt <= 1'b0;
      ot    <= 1'b0;
      ctrl_u.drive(1'b1, 3'h0, 3'h0);
      t0 = cyc;
      wait_st(4'h4);
      n = cyc - t0;
   endtask

   // 0: both gates off, 1: low side on, 2: high side on
   function automatic logic cond(input int w, input int p);
      case (w)
         0:       cond = !g_hi[p] && !g_lo[p];
         1:       cond = g_lo[p];
         default: cond = g_hi[p];
      endcase
   endfunction

   task automatic wait_on(input int w, input int p);
      do begin
         @(posedge clk);
      end while (cond(w, p) !== 1'b1);
   endtask

   task automatic count(input int w, input int p, output int n);
      n = 0;
      while (cond(w, p) === 1'b1 && n < 5000) begin
         n++;
         @(posedge clk);
      end
   endtask

   task automatic t_reset;
      logic [31:0] s;
      repeat (3) @(posedge clk);
      chk({g_hi, g_lo, hiz, f_oe, wreq}, 11'h01D);
      chk(rdata, 32'h0);
      rst_n <= 1'b1;
      bus(1'b0, `BGDC_OFS_DEAD, 32'h0, s);
      chk(s[11:0], 12'h000);
      bus(1'b0, `BGDC_OFS_LSP, 32'h0, s);
      chk(s[11:0], `BGDC_LSP_CYC);
      bus(1'b0, `BGDC_OFS_STATUS, 32'h0, s);
      chk({s[26:15], s[7:0]}, {12'd6, 8'h10});
      bus(1'b1, 4'hC, 32'hFFF, s);
      bus(1'b0, 4'hC, 32'h0, s);
      chk(s, 32'h0);
   endtask

   task automatic t_pwrup;
      logic [31:0] s;
      int n;
      ctrl_u.drive(1'b1, 3'h7, 3'h7);
      repeat (PU + 10) @(posedge clk);
      bus(1'b0, `BGDC_OFS_STATUS, 32'h0, s);
      chk(s[7:4], 4'h1);
      uv_ok <= 1'b1;
      ctrl_u.drive(1'b0, 3'h7, 3'h7);
      repeat (PU + 10) @(posedge clk);
      bus(1'b0, `BGDC_OFS_STATUS, 32'h0, s);
      chk(s[7:4], 4'h1);
      ctrl_u.drive(1'b1, 3'h7, 3'h7);
      repeat (PU + 10) @(posedge clk);
      bus(1'b0, `BGDC_OFS_STATUS, 32'h0, s);
      chk(s[13:4], 10'h002);
      ctrl_u.drive(1'b1, 3'h0, 3'h0);
      gd_ok <= 1'b1;
      wait_st(4'h4);
      ctrl_u.drive(1'b0, 3'h0, 3'h0);
      repeat (6) @(posedge clk);
      bus(1'b0, `BGDC_OFS_STATUS, 32'h0, s);
      chk(s[7:4], 4'h1);
      pwr_up(n);
      chk(n >= PU && n <= 2 * PU, 1'b1);
   endtask

   task automatic t_gates;
      logic [31:0] s;
      int n;
      bus(1'b1, `BGDC_OFS_LSP, 32'h0, s);
      bus(1'b0, `BGDC_OFS_LSP, 32'h0, s);
      chk(s[11:0], 12'h001);
      bus(1'b1, `BGDC_OFS_DEAD, 32'hFFF, s);
      bus(1'b0, `BGDC_OFS_STATUS, 32'h0, s);
      chk(s[26:15], 12'd1200);
      bus(1'b1, `BGDC_OFS_LSP, 32'h8, s);
      bus(1'b1, `BGDC_OFS_DEAD, 32'd20, s);
      bus(1'b0, `BGDC_OFS_STATUS, 32'h0, s);
      chk(s[26:15], 12'd15);
      for (int p = 0; p < 3; p++) begin
         ctrl_u.drive(1'b1, 3'h0, 3'h1 << p);
         repeat (6) @(posedge clk);
         chk({g_hi, g_lo, hiz}, 9'h007);
         ctrl_u.drive(1'b1, 3'h1 << p, 3'h1 << p);
         wait_on(1, p);
         count(1, p, n);
         chk(n, 8);
         count(0, p, n);
         chk(n, 15);
         chk({g_hi, g_lo}, {3'h1 << p, 3'h0});
         ctrl_u.drive(1'b1, 3'h1 << p, 3'h0);
         count(2, p, n);
         count(0, p, n);
         chk(n, 15);
         chk({g_hi, g_lo}, {3'h0, 3'h1 << p});
         ctrl_u.drive(1'b1, 3'h0, 3'h1 << p);
         repeat (6) @(posedge clk);
         chk({g_hi, g_lo, hiz}, 9'h007);
      end
   endtask

   task automatic t_blank;
      logic [31:0] s;
      ctrl_u.drive(1'b1, 3'h1, 3'h1);
      wait_on(2, 0);
      ctrl_u.drive(1'b1, 3'h1, 3'h0);
      wait_on(0, 0);
      vds <= 6'h01;
      @(posedge clk);
      vds <= 6'h00;
      repeat (10) @(posedge clk);
      bus(1'b0, `BGDC_OFS_STATUS, 32'h0, s);
      chk(s[7:4], 4'h4);
      repeat (30) @(posedge clk);
      vds <= 6'h01;
      @(posedge clk);
      vds <= 6'h00;
      repeat (10) @(posedge clk);
      bus(1'b0, `BGDC_OFS_STATUS, 32'h0, s);
      chk(s[7:0], 8'h81);
      ctrl_u.drive(1'b0, 3'h0, 3'h0);
      repeat (6) @(posedge clk);
   endtask

   task automatic t_faults;
      logic [31:0] s;
      int n;
      for (int k = 0; k < 4; k++) begin
         pwr_up(n);
         ctrl_u.drive(1'b1, 3'h2, 3'h2);
         repeat (40) @(posedge clk);
         case (k)
            0:       vds <= 6'h20;
            1:       shunt <= 1'b1;
            2:       gd_ok <= 1'b0;
            default: ot <= 1'b1;
         endcase
         repeat (6) @(posedge clk);
         bus(1'b0, `BGDC_OFS_STATUS, 32'h0, s);
         chk(s[14:0], {1'b0, 6'h00, 4'h8, 4'h1 << k});
         chk({f_oe, f_out, g_hi, g_lo}, 8'h80);
         vds   <= 6'h00;
         shunt <= 1'b0;
         gd_ok <= 1'b1;
         ot    <= 1'b0;
         repeat (6) @(posedge clk);
         bus(1'b0, `BGDC_OFS_STATUS, 32'h0, s);
         chk({f_oe, s[7:0]}, {1'b1, 4'h8, 4'h1 << k});
         if (k[0])
            uv_ok <= 1'b0;
         else
            ctrl_u.drive(1'b0, 3'h2, 3'h2);
         repeat (6) @(posedge clk);
         bus(1'b0, `BGDC_OFS_STATUS, 32'h0, s);
         chk({f_oe, s[14:0]}, {1'b0, 1'b1, 6'h00, 4'h1, 4'h0});
      end
   endtask

   initial begin
      rst_n = 1'b0;
      uv_ok = 1'b0;
      gd_ok = 1'b0;
      vds   = 6'h00;
      shunt = 1'b0;
      ot    = 1'b0;
      addr  = 4'h0;
      rd    = 1'b0;
      wr    = 1'b0;
      wdata = 32'h0;
      t_reset();
      t_pwrup();
      t_gates();
      t_blank();
      t_faults();
      end_sim();
   end
endmodule // tb_top
